// File: hdl/hscap_pkg.sv
// What this block does
// RULE1 - Capability ID byte at 5Ch reads 06h
// RULE2 - Next-item pointer at 5Dh reads 00h
// RULE3 - Board-ready set once when ready after reset
// RULE4 - Removal-pending set when ejector opens, board-ready clear
// RULE5 - Software writes never set either flag
// RULE6 - Enumeration output follows either flag set
// RULE7 - Mask bit gates output, flags still set
// RULE8 - Lamp held high until preload done, ejector closed
// RULE9 - Afterwards lamp follows LED control bit
// RULE10 - Reserved control bits read zero, ignore writes
// RULE11 - Control/status byte resets to 00h
// RULE12 - Write one clears a flag; zero keeps it
package hscap_pkg;

  // Configuration space placement
  localparam logic [7:0]  HSCAP_ID_OFFSET    = 8'h5C;  // Capability identifier byte
  localparam logic [7:0]  HSCAP_NEXT_OFFSET  = 8'h5D;  // Next-item pointer byte
  localparam logic [7:0]  HSCAP_CSR_OFFSET   = 8'h5E;  // Control/status byte
  localparam logic [5:0]  HSCAP_DWORD_INDEX  = 6'h17;  // Dword holding the three bytes

  // Constant contents
  localparam logic [7:0]  HSCAP_ID_VALUE     = 8'h06;  // Hot swap capability code
  localparam logic [7:0]  HSCAP_NEXT_VALUE   = 8'h00;  // End of capability list
  localparam logic [7:0]  HSCAP_CSR_RESET    = 8'h00;  // Control/status after reset

  // Control/status byte fields
  localparam int          HSCAP_READY_BIT    = 7;      // Board-ready flag
  localparam int          HSCAP_REMOVE_BIT   = 6;      // Removal-pending flag
  localparam int          HSCAP_LED_BIT      = 3;      // LED drive bit
  localparam int          HSCAP_MASK_BIT     = 1;      // Enumeration mask bit

  // Configuration access request
  typedef struct packed {
    logic        rd;     // Read strobe, one cycle
    logic        wr;     // Write strobe, one cycle
    logic [7:2]  addr;   // Dword address
    logic [3:0]  be;     // Byte enables
    logic [31:0] wdata;  // Write data
  } hscap_req_s;

  // Hardware status inputs from the misc control register
  typedef struct packed {
    logic rom_preload_busy;   // Serial ROM preload running
    logic ejector_open_flag;  // Ejector handle open
  } hscap_stat_s;

endpackage : hscap_pkg

// File: hdl/hscap_regs.sv
`timescale 1ns/1ps
module hscap_regs
  import hscap_pkg::*;
(
  input  wire logic        clk_i,       // Bus clock, 125 MHz
  input  wire logic        reset_n_i,   // Bus reset, async, active low
  input  wire hscap_req_s  cfg_req_i,   // Configuration access
  input  wire hscap_stat_s hw_stat_i,   // Preload and ejector status
  output logic [31:0]      cfg_rdata_o, // Read data, registered
  output logic             cfg_rvalid_o, // Read data valid pulse
  output logic             enumeration_signal_out_o, // Enumeration request, high active
  output logic             status_lamp_out_o         // Status lamp drive
);

  // Whole block state
  typedef struct packed {
    logic        board_ready_flag;     // Insertion complete
    logic        removal_pending_flag; // Extraction requested
    logic        led_drive_bit;        // Lamp control by software
    logic        enum_mask_bit;        // Enumeration output mask
    logic        ready_armed;          // Board-ready may still fire
    logic        lamp_released;        // Lamp handed to software
    logic        enum_out;             // Enumeration output flop
    logic        lamp_out;             // Lamp output flop
    logic        rvalid;               // Read answer valid
    logic [31:0] rdata;                // Read answer data
  } hscap_state_s;

  hscap_state_s state_reg;   // Registered state
  hscap_state_s state_next;  // Next state

  logic       hit;        // Access targets our dword
  logic       csr_wr;     // Write to control/status lane
  logic [7:0] csr_wbyte;  // Written control/status byte
  logic       ready_set;  // Hardware sets board-ready
  logic       remove_set; // Hardware sets removal-pending
  logic       ready_clr;  // Software clears board-ready
  logic       remove_clr; // Software clears removal-pending
  logic [7:0] csr_view;   // Control/status as read

  // Decode and flag conditions
  always_comb begin
    hit        = (cfg_req_i.addr == HSCAP_DWORD_INDEX);
    csr_wr     = cfg_req_i.wr && hit && cfg_req_i.be[2];
    csr_wbyte  = cfg_req_i.wdata[23:16];
    // Only hardware conditions may set the flags [RULE5]
    ready_set  = state_reg.ready_armed && !hw_stat_i.rom_preload_busy
                 && !hw_stat_i.ejector_open_flag
                 && !state_reg.removal_pending_flag;        // [RULE3]
    remove_set = hw_stat_i.ejector_open_flag
                 && !state_reg.board_ready_flag;            // [RULE4]
    ready_clr  = csr_wr && csr_wbyte[HSCAP_READY_BIT];      // [RULE12]
    remove_clr = csr_wr && csr_wbyte[HSCAP_REMOVE_BIT];     // [RULE12]
    // Reserved bits always zero [RULE10]
    csr_view   = 8'h00;
    csr_view[HSCAP_READY_BIT]  = state_reg.board_ready_flag;
    csr_view[HSCAP_REMOVE_BIT] = state_reg.removal_pending_flag;
    csr_view[HSCAP_LED_BIT]    = state_reg.led_drive_bit;
    csr_view[HSCAP_MASK_BIT]   = state_reg.enum_mask_bit;
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    // Set wins over a clear in the same cycle
    state_next.board_ready_flag = ready_set
      || (state_reg.board_ready_flag && !ready_clr);        // [RULE3] [RULE12]
    state_next.removal_pending_flag = remove_set
      || (state_reg.removal_pending_flag && !remove_clr);   // [RULE4] [RULE12]
    // Board-ready fires only once per reset
    if (ready_set) begin
      state_next.ready_armed = 1'b0;                        // [RULE3]
    end
    // Writable control bits; reserved bits dropped
    if (csr_wr) begin
      state_next.led_drive_bit = csr_wbyte[HSCAP_LED_BIT];  // [RULE10]
      state_next.enum_mask_bit = csr_wbyte[HSCAP_MASK_BIT];
    end
    // Lamp released once preload done and ejector closed
    if (!hw_stat_i.rom_preload_busy && !hw_stat_i.ejector_open_flag) begin
      state_next.lamp_released = 1'b1;                      // [RULE8]
    end
    // Enumeration output from either flag, gated by mask
    state_next.enum_out = (state_next.board_ready_flag
                           || state_next.removal_pending_flag)
                          && !state_next.enum_mask_bit;     // [RULE6] [RULE7]
    // Lamp high until released, then software bit
    state_next.lamp_out = state_next.lamp_released
                          ? state_next.led_drive_bit : 1'b1; // [RULE8] [RULE9]
    // Read answer
    state_next.rvalid = cfg_req_i.rd;
    state_next.rdata  = 32'h0000_0000;
    if (cfg_req_i.rd && hit) begin
      state_next.rdata = {8'h00, csr_view, HSCAP_NEXT_VALUE,
                          HSCAP_ID_VALUE};                  // [RULE1] [RULE2]
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Control/status byte to 00h, lamp held high [RULE11]
      state_reg <= '{board_ready_flag:     HSCAP_CSR_RESET[HSCAP_READY_BIT],  // Flag clear
                     removal_pending_flag: HSCAP_CSR_RESET[HSCAP_REMOVE_BIT], // Flag clear
                     led_drive_bit:        HSCAP_CSR_RESET[HSCAP_LED_BIT],    // LED bit off
                     enum_mask_bit:        HSCAP_CSR_RESET[HSCAP_MASK_BIT],   // Output enabled
                     ready_armed:          1'b1,                              // May fire once
                     lamp_released:        1'b0,                              // Lamp held
                     enum_out:             1'b0,                              // No request
                     lamp_out:             1'b1,                              // Lamp high
                     rvalid:               1'b0,                              // No answer
                     rdata:                32'h0000_0000};                    // Bus quiet
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign cfg_rdata_o              = state_reg.rdata;
  assign cfg_rvalid_o             = state_reg.rvalid;
  assign enumeration_signal_out_o = state_reg.enum_out;
  assign status_lamp_out_o        = state_reg.lamp_out;

  // Checks sit beside the logic; each label carries its rule

  // Read path: constant bytes, answer timing, reserved bits

  // Identifier and pointer bytes of every hit read
  AST_ID_READ: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE1] [RULE2]
    cfg_req_i.rd && hit |=> cfg_rdata_o[7:0] == 8'h06 && cfg_rdata_o[15:8] == 8'h00)
    else $error("capability id or pointer wrong");

  // Every read is answered one cycle later
  AST_RD_VALID: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE1]
    cfg_req_i.rd |=> cfg_rvalid_o)
    else $error("read answer missing");

  // No read, no answer and a quiet data bus
  AST_RD_QUIET: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE2]
    !cfg_req_i.rd |=> !cfg_rvalid_o && cfg_rdata_o == 32'h0000_0000)
    else $error("read answer without request");

  // Reads of other dwords return zero
  AST_RD_MISS: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE1]
    cfg_req_i.rd && !hit |=> cfg_rdata_o == 32'h0000_0000)
    else $error("foreign dword read nonzero");

  // Reserved control/status bits read zero
  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE10]
    cfg_rvalid_o |-> cfg_rdata_o[21:20] == 2'b00 && !cfg_rdata_o[18] && !cfg_rdata_o[16])
    else $error("reserved control bit nonzero");

  // Byte above the control/status byte reads zero
  AST_TOP_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE10]
    cfg_rvalid_o |-> cfg_rdata_o[31:24] == 8'h00)
    else $error("upper byte nonzero");

  // Control/status lane shows the state of the read cycle
  AST_CSR_READ: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE10]
    cfg_req_i.rd && hit |=> cfg_rdata_o[23:16] == $past(csr_view))
    else $error("control byte read wrong");

  // Flag setting by hardware only

  // Board-ready set the cycle after its condition, then disarmed
  AST_READY_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE3]
    ready_set |=> state_reg.board_ready_flag ##1 !ready_set)
    else $error("board ready not set once");

  // Board-ready only rises out of its full condition
  AST_READY_COND: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE3]
    $rose(state_reg.board_ready_flag) |-> !$past(hw_stat_i.rom_preload_busy)
    && !$past(hw_stat_i.ejector_open_flag) && !$past(state_reg.removal_pending_flag))
    else $error("board ready set too early");

  // A cleared board-ready is still clear in the cycle after it falls
  AST_READY_ONCE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE3]
    $fell(state_reg.board_ready_flag) |=> !state_reg.board_ready_flag)
    else $error("board ready set twice");

  // Removal-pending follows an open ejector while board-ready is clear
  AST_REMOVE_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE4]
    hw_stat_i.ejector_open_flag && !state_reg.board_ready_flag
    |=> state_reg.removal_pending_flag)
    else $error("removal pending not set");

  // Removal-pending only rises out of its condition
  AST_REMOVE_COND: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE4]
    $rose(state_reg.removal_pending_flag) |-> $past(hw_stat_i.ejector_open_flag)
    && !$past(state_reg.board_ready_flag))
    else $error("removal pending set without cause");

  // Software cannot set board-ready
  AST_NO_SW_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE5]
    csr_wr && !state_reg.board_ready_flag && !ready_set |=> !state_reg.board_ready_flag)
    else $error("software set board ready");

  // Software cannot set removal-pending
  AST_NO_SW_SET_RM: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE5]
    csr_wr && !state_reg.removal_pending_flag && !remove_set
    |=> !state_reg.removal_pending_flag)
    else $error("software set removal pending");

  // Enumeration output and its mask

  // A rising flag raises the unmasked output at once
  AST_ENUM_RISE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE6]
    ($rose(state_reg.board_ready_flag) || $rose(state_reg.removal_pending_flag))
    && !state_reg.enum_mask_bit |-> enumeration_signal_out_o)
    else $error("enumeration output missing");

  // Any set flag drives the unmasked output
  AST_ENUM_ON: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE6]
    (state_reg.board_ready_flag || state_reg.removal_pending_flag)
    && !state_reg.enum_mask_bit |-> enumeration_signal_out_o)
    else $error("enumeration output low with flag set");

  // No flag, no enumeration request
  AST_ENUM_OFF: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE6] [RULE12]
    !state_reg.board_ready_flag && !state_reg.removal_pending_flag
    |-> !enumeration_signal_out_o)
    else $error("enumeration output without flag");

  // Mask bit holds the output low
  AST_MASKED: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE7]
    state_reg.enum_mask_bit |-> !enumeration_signal_out_o)
    else $error("masked enumeration driven");

  // Removal-pending still set while the output is masked
  AST_MASK_FLAGS: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE7]
    remove_set && state_reg.enum_mask_bit |=> state_reg.removal_pending_flag)
    else $error("masked flag not set");

  // Mask bit takes the written value
  AST_MASK_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE7]
    csr_wr |=> state_reg.enum_mask_bit == $past(csr_wbyte[HSCAP_MASK_BIT]))
    else $error("mask bit write lost");

  // Status lamp

  // Lamp high until handed to software
  AST_LAMP_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE8]
    !state_reg.lamp_released |-> status_lamp_out_o)
    else $error("lamp not held high");

  // Busy preload or open ejector keeps a held lamp high
  AST_LAMP_BUSY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE8]
    (hw_stat_i.rom_preload_busy || hw_stat_i.ejector_open_flag)
    && !state_reg.lamp_released |=> status_lamp_out_o)
    else $error("lamp released too early");

  // Preload idle and ejector closed hand the lamp over
  AST_RELEASE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE8]
    !hw_stat_i.rom_preload_busy && !hw_stat_i.ejector_open_flag
    |=> state_reg.lamp_released)
    else $error("lamp not handed over");

  // Lamp follows a written LED bit once released
  AST_LAMP_SW: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE9]
    csr_wr && state_reg.lamp_released |=> status_lamp_out_o == $past(csr_wbyte[3]))
    else $error("lamp ignores led bit");

  // LED bit takes the written value
  AST_LED_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE9]
    csr_wr |=> state_reg.led_drive_bit == $past(csr_wbyte[HSCAP_LED_BIT]))
    else $error("led bit write lost");

  // Released lamp level equals the LED bit
  AST_LAMP_FOLLOW: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE9]
    state_reg.lamp_released |-> status_lamp_out_o == state_reg.led_drive_bit)
    else $error("lamp differs from led bit");

  // Reset values

  // Control/status byte reads its reset value after release
  AST_RESET_CSR: assert property (@(posedge clk_i) // [RULE11]
    !$past(reset_n_i) && reset_n_i |-> csr_view == HSCAP_CSR_RESET)
    else $error("control byte not reset");

  // Outputs quiet and lamp high after release
  AST_RESET_OUT: assert property (@(posedge clk_i) // [RULE8] [RULE11]
    !$past(reset_n_i) && reset_n_i
    |-> !enumeration_signal_out_o && status_lamp_out_o && !cfg_rvalid_o)
    else $error("outputs not at reset values");

  // Write one to clear, write zero to keep

  // Clearing board-ready drops the output unless another flag holds it
  AST_W1C: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE12]
    ready_clr && !ready_set |=> !state_reg.board_ready_flag ##1 (!enumeration_signal_out_o
    || state_reg.removal_pending_flag || state_reg.board_ready_flag))
    else $error("write one did not clear");

  // Clearing removal-pending
  AST_W1C_RM: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE12]
    remove_clr && !remove_set |=> !state_reg.removal_pending_flag)
    else $error("write one did not clear removal");

  // Zero in the board-ready bit keeps the flag
  AST_W0_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE12]
    csr_wr && !csr_wbyte[HSCAP_READY_BIT] && state_reg.board_ready_flag
    |=> state_reg.board_ready_flag)
    else $error("write zero cleared board ready");

  // Zero in the removal-pending bit keeps the flag
  AST_W0_KEEP_RM: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE12]
    csr_wr && !csr_wbyte[HSCAP_REMOVE_BIT] && state_reg.removal_pending_flag
    |=> state_reg.removal_pending_flag)
    else $error("write zero cleared removal pending");

endmodule : hscap_regs

// File: verification/hscap_chassis_model.sv
`timescale 1ns/1ps
// Chassis side: preload engine busy after each reset, ejector handle level
module hscap_chassis_model
  import hscap_pkg::*;
#(
  parameter int PRELOAD_CYC = 20  // Preload length in clocks
) (
  input  wire logic   clk_i,     // Bus clock
  input  wire logic   reset_n_i, // Bus reset, active low
  input  wire logic   eject_i,   // Handle opened by the operator
  output hscap_stat_s stat_o     // Status towards the block
);
  int cnt_reg;  // Clocks since reset release, held once it reaches PRELOAD_CYC

  // Preload runs a fixed time after every reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 0;
    end else if (cnt_reg < PRELOAD_CYC) begin
      cnt_reg <= cnt_reg + 1;
    end
  end

  assign stat_o.rom_preload_busy  = (cnt_reg < PRELOAD_CYC);  // Busy until count ends
  assign stat_o.ejector_open_flag = eject_i;                  // Handle level as commanded
endmodule : hscap_chassis_model

// File: verification/hot_swap_capability_regs_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
// Self-checking bench for the hot swap capability registers
module hot_swap_capability_regs_bench
  import hscap_pkg::*;
;
  logic        clk_i = 1'b0;   // Bus clock
  logic        reset_n_i = 1'b0; // Bus reset, active low
  logic        eject = 1'b0;   // Ejector command to the chassis model
  hscap_req_s  req = '0;       // Configuration request
  hscap_stat_s stat;           // Chassis status
  logic [31:0] rdata;          // Read data
  logic        rvalid;         // Read valid pulse
  logic        enum_out;       // Enumeration output
  logic        lamp;           // Lamp output
  int          mismatches = 0; // Failed comparisons
  int          num_checks = 0; // All comparisons

  // Clock, 8 ns period
  always #4 clk_i = ~clk_i;

  hscap_chassis_model #(.PRELOAD_CYC(20)) partner (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .eject_i(eject), .stat_o(stat));
  hscap_regs DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_req_i(req), .hw_stat_i(stat),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .enumeration_signal_out_o(enum_out),
    .status_lamp_out_o(lamp));

  // One write with data in lane 2, junk elsewhere; waits for outputs to follow
  task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [7:0] d);
    @(posedge clk_i); #1;
    req.wr = 1'b1;
    req.addr = a;
    req.be = b;
    req.wdata = {8'hA5, d, 16'h5AA5};
    @(posedge clk_i); #1;
    req.wr = 1'b0;
    req.wdata = ~req.wdata;
    @(posedge clk_i); #1;
  endtask : wr

  // One read, answer checked in the cycle after the taking edge
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk_i); #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk_i); #1;
    req.rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask : rd

  // Compare enumeration and lamp levels
  task automatic outs(input logic en, input logic lp);
    `CHK({enum_out, lamp}, {en, lp})
  endtask : outs

  // Counts, verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // Watchdog against a hang
  initial begin
    #20000;
    mismatches++;
    results;
  end

  // Test sequence
  initial begin
    repeat (3) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    rd(6'h17, 32'h0000_0006);
    outs(1'b0, 1'b1);
    wr(6'h17, 4'h4, 8'h00); outs(1'b0, 1'b1);
    repeat (25) @(posedge clk_i);
    #1 rd(6'h17, 32'h0080_0006);
    outs(1'b1, 1'b0);
    eject = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rd(6'h17, 32'h0080_0006);
    eject = 1'b0;
    wr(6'h17, 4'h4, 8'h00); rd(6'h17, 32'h0080_0006);
    wr(6'h17, 4'h4, 8'h3E); rd(6'h17, 32'h008A_0006);
    outs(1'b0, 1'b1);
    wr(6'h17, 4'h4, 8'hCA); rd(6'h17, 32'h000A_0006);
    wr(6'h17, 4'h4, 8'hCA); rd(6'h17, 32'h000A_0006);
    wr(6'h16, 4'h4, 8'h00); wr(6'h17, 4'hB, 8'h00);
    rd(6'h17, 32'h000A_0006); rd(6'h16, 32'h0000_0000);
    eject = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 rd(6'h17, 32'h004A_0006);
    outs(1'b0, 1'b1);
    wr(6'h17, 4'h4, 8'h08); rd(6'h17, 32'h0048_0006); outs(1'b1, 1'b1);
    eject = 1'b0;
    wr(6'h17, 4'h4, 8'h48); rd(6'h17, 32'h0008_0006); outs(1'b0, 1'b1);
    repeat (4) @(posedge clk_i);
    #1 rd(6'h17, 32'h0008_0006);
    reset_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    rd(6'h17, 32'h0000_0006); outs(1'b0, 1'b1);
    results;
  end
endmodule : hot_swap_capability_regs_bench
